// ### core/irm_regs.vh
// Constants of the internal RAM, stack and register bank block.
// Assumes byte addresses within segment 0 and a 16-bit word datapath.
`ifndef IRM_REGS_VH
`define IRM_REGS_VH
`define IRM_AREA_BASE     24'h00F000
`define IRM_SEG_ZERO      8'h00
`define IRM_AREA_TOP4K    4'hF
`define IRM_PAGE_THREE    2'h3
`define IRM_EXTENDED_FUNCTION_AREA_LO       16'hF000
`define IRM_EXTENDED_FUNCTION_AREA_HI       16'hF1FF
`define IRM_RAM_LO        16'hFA00
`define IRM_RAM_HI        16'hFDFF
`define IRM_RAM_BIT_LO    16'hFD00
`define IRM_SFR_LO        16'hFE00
`define IRM_EXTENDED_FUNCTION_AREA_BIT_LO   16'hF100
`define IRM_SFR_BIT_LO    16'hFF00
`define IRM_RAM_WORDS     512
`define IRM_STK_TOP       16'hFC00
`define IRM_STK_TOP512    16'hFE00
`define IRM_STK_LOW256    16'hFA00
`define IRM_STK_LOW128    16'hFB00
`define IRM_STK_LOW64     16'hFB80
`define IRM_STK_LOW32     16'hFBC0
`define IRM_STKSZ_256     3'h0
`define IRM_STKSZ_128     3'h1
`define IRM_STKSZ_64      3'h2
`define IRM_STKSZ_32      3'h3
`define IRM_STKSZ_512     3'h7
`define IRM_STEP_WORD     16'h0002
`define IRM_CP_RESET      16'hFC00
`define IRM_PROT_BITS     25
`define IRM_BANK_SPAN     16'h001F
`endif

// ### core/irm_protect.v
// Protected hardware-settable flags, 25 bits.
// Assumes the core flags which bits a software write really targets.
`timescale 1ns/1ps
`include "irm_regs.vh"
module irm_protect (
    input  wire                       clock,      // System clock.
    input  wire                       rst_n,      // Async reset, active low.
    input  wire [`IRM_PROT_BITS-1:0]  hwSet,      // Hardware set pulses.
    input  wire [`IRM_PROT_BITS-1:0]  swTarget,   // Bits a write really targets.
    input  wire [`IRM_PROT_BITS-1:0]  swValue,    // Values for targeted bits.
    output wire [`IRM_PROT_BITS-1:0]  flags       // Current protected flags.
);
    reg [`IRM_PROT_BITS-1:0] flag_q;
    genvar i;
    generate
        for (i = 0; i < `IRM_PROT_BITS; i = i + 1) begin : gBit
            // A hardware set wins over a simultaneous software clear.
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    flag_q[i] <= 1'b0;
                end else if (hwSet[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (swTarget[i]) begin
                    flag_q[i] <= swValue[i];
                end
            end
        end
    endgenerate
    assign flags = flag_q;
endmodule // irm_protect

// ### core/irm_stack.v
// Stack pointer with combinational size decode of the lower and upper limits.
// Assumes push and pop requests never come together.
`timescale 1ns/1ps
`include "irm_regs.vh"
module irm_stack (
    input  wire        clock,       // System clock.
    input  wire        rst_n,       // Async reset, active low.
    input  wire [2:0]  stackSize,   // Stack size field.
    input  wire        spWrite,     // Load stack pointer.
    input  wire [15:0] spWdata,     // Stack pointer load value.
    input  wire        push,        // Word push.
    input  wire        pop,         // Word pop.
    output reg  [15:0] spNow,       // Current stack pointer.
    output reg  [15:0] lowLimit,    // Decoded lower limit.
    output reg  [15:0] highLimit,   // Decoded upper limit.
    output reg         circularOk   // Circular flush and fill allowed.
);
    always @* begin
        highLimit  = `IRM_STK_TOP;
        circularOk = 1'b1;
        case (stackSize)
            `IRM_STKSZ_256: lowLimit = `IRM_STK_LOW256;
            `IRM_STKSZ_128: lowLimit = `IRM_STK_LOW128;
            `IRM_STKSZ_64:  lowLimit = `IRM_STK_LOW64;
            `IRM_STKSZ_32:  lowLimit = `IRM_STK_LOW32;
            `IRM_STKSZ_512: begin
                lowLimit   = `IRM_STK_LOW256;
                highLimit  = `IRM_STK_TOP512;
                circularOk = 1'b0;
            end
            // Reserved codes fall back to the reset size.
            default:        lowLimit = `IRM_STK_LOW256;
        endcase
    end
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            spNow <= `IRM_STK_TOP;
        end else if (spWrite) begin
            spNow <= {spWdata[15:1], 1'b0};
        end else if (push) begin
            spNow <= spNow - `IRM_STEP_WORD;
        end else if (pop) begin
            spNow <= spNow + `IRM_STEP_WORD;
        end
    end
endmodule // irm_stack

// ### core/irm_core.v
// Internal RAM, address decode, stack, register bank and bit protection.
// Assumes one request per cycle from the core or the event transfer unit.
`timescale 1ns/1ps
`include "irm_regs.vh"
module irm_core (
    input  wire        clock,         // System clock.
    input  wire        rst_n,         // Async reset, active low.
    input  wire        req,           // Access request.
    input  wire        reqWrite,      // 1 write, 0 read.
    input  wire        reqByte,       // Byte access.
    input  wire        reqFetch,      // Code fetch.
    input  wire        reqTransfer,   // Event transfer access, page-free.
    input  wire        reqGpr,        // Short register-bank access.
    input  wire [3:0]  gprIndex,      // Register number.
    input  wire [23:0] reqAddr,       // Linear or paged byte address.
    input  wire [1:0]  pageSel,       // Selected data page pointer number.
    input  wire [9:0]  pagePtr,       // Value of selected page pointer.
    input  wire        reqPaged,      // Address uses page pointers.
    input  wire [15:0] reqWdata,      // Write data.
    input  wire        bitOp,         // Single-bit access.
    input  wire [3:0]  bitPos,        // Bit position in word.
    input  wire        bitVal,        // Bit write value.
    input  wire [2:0]  stackSize,     // Stack size field of system config.
    input  wire        push,          // Stack push with reqWdata.
    input  wire        pop,           // Stack pop.
    input  wire        cpWrite,       // Load context pointer.
    input  wire        ctxSwitch,     // Switch context, saves old pointer.
    input  wire [15:0] cpWdata,       // New context base.
    input  wire [15:0] lowLimitW,     // Lower limit load value.
    input  wire [15:0] highLimitW,    // Upper limit load value.
    input  wire        limitWrite,    // Load both limits.
    input  wire [24:0] hwSet,         // Hardware flag set pulses.
    input  wire [24:0] swTarget,      // Protected bits a write targets.
    input  wire [24:0] swValue,       // Values for targeted bits.
    output reg  [15:0] rdata,         // Read data.
    output reg         rvalid,        // Read data valid pulse.
    output reg         accessErr,     // Refused access pulse.
    output reg         extAccess,     // Access goes outside internal area.
    output reg  [15:0] cpNow,         // Active context base.
    output reg  [15:0] cpSaved,       // Context saved by switch.
    output reg  [15:0] spOut,         // Stack pointer.
    output reg  [15:0] stackLowReg,   // Lower limit register.
    output reg  [15:0] stackHighReg,  // Upper limit register.
    output reg         stackOvf,      // Push below lower limit.
    output reg         stackUnf,      // Pop above upper limit.
    output reg         circular,      // Circular operation allowed.
    output reg  [24:0] protFlags      // Protected flags.
);
    reg  [15:0] ram [0:`IRM_RAM_WORDS-1];
    reg  [15:0] sfrWord_q;
    reg  [15:0] cp_q;
    reg  [23:0] addr;
    reg  [15:0] off;
    reg         inArea;
    reg         inRam;
    reg         inSfr;
    reg         bitOk;
    reg         refuse;
    reg  [15:0] oldWord;
    reg  [15:0] newWord;
    wire [15:0] spCur;
    wire [15:0] lowDec;
    wire [15:0] highDec;
    wire        circDec;
    wire [24:0] flags;
    wire [8:0]  ramIdx;
    wire [8:0]  spIdx;

    irm_stack uStack (
        .clock      (clock),
        .rst_n      (rst_n),
        .stackSize  (stackSize),
        .spWrite    (1'b0),
        .spWdata    (16'h0000),
        .push       (push),
        .pop        (pop),
        .spNow      (spCur),
        .lowLimit   (lowDec),
        .highLimit  (highDec),
        .circularOk (circDec)
    );

    irm_protect uProt (
        .clock    (clock),
        .rst_n    (rst_n),
        .hwSet    (hwSet),
        .swTarget (swTarget),
        .swValue  (swValue),
        .flags    (flags)
    );

    // Address formation and decode.
    always @* begin
        if (reqGpr) begin
            addr = {`IRM_SEG_ZERO, cp_q + {11'h000, gprIndex, 1'b0}};
        end else if (reqPaged && !reqTransfer) begin
            addr = {pagePtr, reqAddr[13:0]};
        end else begin
            addr = reqAddr;
        end
        off    = addr[15:0];
        inArea = (addr[23:16] == `IRM_SEG_ZERO) && (off[15:12] == `IRM_AREA_TOP4K);
        inRam  = inArea && off >= `IRM_RAM_LO && off <= `IRM_RAM_HI;
        inSfr  = inArea && !inRam;
        bitOk  = reqGpr || (inRam && off >= `IRM_RAM_BIT_LO)
                 || (off >= `IRM_SFR_BIT_LO)
                 || (off >= `IRM_EXTENDED_FUNCTION_AREA_BIT_LO && off <= `IRM_EXTENDED_FUNCTION_AREA_HI);
        refuse = (reqFetch && (addr[0] || inSfr))
                 || (bitOp && !(inArea && bitOk))
                 || (reqPaged && !reqTransfer && inRam
                     && pagePtr[1:0] != `IRM_PAGE_THREE && pageSel == pageSel);
    end

    // Word index counts from the RAM base, so the RAM's first word is entry zero.
    wire [15:0] ramOff = off - `IRM_RAM_LO;
    wire [15:0] spOff  = spCur - `IRM_RAM_LO;
    assign ramIdx = ramOff[9:1];
    assign spIdx  = spOff[9:1];

    // Merge of a write into the old word, except byte writes outside the RAM, which clear the other byte.
    always @* begin
        oldWord = inRam ? ram[ramIdx] : sfrWord_q;
        newWord = oldWord;
        if (bitOp) begin
            newWord[bitPos] = bitVal;
        end else if (!reqByte) begin
            newWord = reqWdata;
        end else if (inRam) begin
            if (addr[0]) newWord[15:8] = reqWdata[7:0];
            else         newWord[7:0]  = reqWdata[7:0];
        end else if (addr[0]) begin
            newWord = {reqWdata[7:0], 8'h00};
        end else begin
            newWord = {8'h00, reqWdata[7:0]};
        end
    end

    always @(posedge clock) begin
        if (req && !refuse && reqWrite && inRam) begin
            ram[ramIdx] <= newWord;
        end else if (push) begin
            ram[spIdx - 9'h001] <= reqWdata;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sfrWord_q    <= 16'h0000;
            cp_q         <= `IRM_CP_RESET;
            cpSaved      <= `IRM_CP_RESET;
            rdata        <= 16'h0000;
            rvalid       <= 1'b0;
            accessErr    <= 1'b0;
            extAccess    <= 1'b0;
            stackLowReg  <= `IRM_STK_LOW256;
            stackHighReg <= `IRM_STK_TOP;
            stackOvf     <= 1'b0;
            stackUnf     <= 1'b0;
        end else begin
            rvalid    <= req && !reqWrite && !refuse && inArea;
            accessErr <= req && refuse;
            extAccess <= req && !inArea;
            stackOvf  <= push && (spCur - `IRM_STEP_WORD) < stackLowReg;
            stackUnf  <= pop && spCur >= stackHighReg;
            if (req && !refuse && !reqWrite) begin
                if (inRam) rdata <= ram[ramIdx];
                else       rdata <= sfrWord_q;
            end else if (pop) begin
                rdata <= ram[spIdx];
            end
            if (req && !refuse && reqWrite && inSfr) begin
                sfrWord_q <= newWord;
            end
            if (ctxSwitch) begin
                cpSaved <= cp_q;
            end
            if (cpWrite || ctxSwitch) begin
                cp_q <= {cpWdata[15:1], 1'b0};
            end
            if (limitWrite) begin
                stackLowReg  <= lowLimitW;
                stackHighReg <= highLimitW;
            end
        end
    end

    // Registered copies keep every output straight from a flip-flop.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpNow     <= `IRM_CP_RESET;
            spOut     <= `IRM_STK_TOP;
            circular  <= 1'b1;
            protFlags <= 25'h0000000;
        end else begin
            cpNow     <= cp_q;
            spOut     <= spCur;
            circular  <= circDec;
            protFlags <= flags;
        end
    end
endmodule // irm_core

// ### tb/irm_core_asserts.sv
// Port-level assertions for the internal RAM, stack and register bank block.
// Assumes it is bound into irm_core and sees only that module's ports.
`timescale 1ns/1ps
module irm_core_chk (
    input wire logic        clock, rst_n, req, reqWrite, reqFetch, reqPaged, reqGpr, bitOp,
    input wire logic        push, pop, cpWrite, ctxSwitch, accessErr, extAccess, circular,
    input wire logic [23:0] reqAddr,
    input wire logic [2:0]  stackSize,
    input wire logic [15:0] cpWdata, cpNow, cpSaved, spOut,
    input wire logic [24:0] hwSet, swTarget, protFlags
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [15:0] spBase_q, cpNew_q, cpOld_q;
    logic [24:0] hwBase_q;
    // The bases remember the value at the cause, so a late update is still judged exactly.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            spBase_q <= 16'hFC00;
            cpNew_q  <= 16'hFC00;
            cpOld_q  <= 16'hFC00;
            hwBase_q <= 25'h0;
        end else begin
            if (push || pop) spBase_q <= spOut;
            if (cpWrite || ctxSwitch) cpNew_q <= cpWdata;
            if (cpWrite || ctxSwitch) cpOld_q <= cpNow;
            if (hwSet != 25'h0) hwBase_q <= hwSet;
        end
    end
    a_odd_fetch: assert property (
        req && reqFetch && reqAddr[0] |=> accessErr) else $error("odd fetch accepted");
    a_ext_space: assert property (
        req && !reqPaged && !reqGpr && !bitOp && !reqFetch
        && (reqAddr[23:16] != 8'h00 || reqAddr[15:12] != 4'hF) |=> extAccess)
        else $error("outside access not flagged");
    a_bit_area: assert property (
        req && bitOp && !reqGpr && !reqPaged && reqAddr[23:8] == 16'h00FA |=> accessErr)
        else $error("bit access outside bit area accepted");
    a_push_dec: assert property (
        push |=> ##[0:3] spOut == spBase_q - 16'h0002) else $error("push step wrong");
    a_pop_inc: assert property (
        pop |=> ##[0:3] spOut == spBase_q + 16'h0002) else $error("pop step wrong");
    a_circ_size: assert property (
        $stable(stackSize) [*3] |-> circular == (stackSize != 3'h7))
        else $error("circular mode wrong for size");
    a_cp_load: assert property (
        cpWrite |=> ##[0:2] cpNow == cpNew_q) else $error("context base not loaded");
    a_ctx_save: assert property (
        ctxSwitch |=> ##[0:2] (cpSaved == cpOld_q && cpNow == cpNew_q))
        else $error("context switch wrong");
    a_hw_wins: assert property (
        hwSet != 25'h0 |=> ##[0:2] (protFlags & hwBase_q) == hwBase_q)
        else $error("hardware flag not set");
    a_sw_only: assert property (
        ($past(protFlags) & ~protFlags & ~$past(swTarget) & ~$past(swTarget, 2)
        & ~$past(swTarget, 3)) == 25'h0) else $error("untargeted flag cleared");
endmodule // irm_core_chk
bind irm_core irm_core_chk u_chk (.clock, .rst_n, .req, .reqWrite, .reqFetch, .reqPaged,
    .reqGpr, .bitOp, .push, .pop, .cpWrite, .ctxSwitch, .accessErr, .extAccess, .circular,
    .reqAddr, .stackSize, .cpWdata, .cpNow, .cpSaved, .spOut, .hwSet, .swTarget, .protFlags);

// ### tb/irm_flag_src.sv
// Model of the timer, serial, trap and peripheral sources of the protected flags.
// Assumes fire is a one-cycle request from the bench.
`timescale 1ns/1ps
module irm_flag_src (
    input  wire logic        clock,          // System clock.
    input  wire logic        fire,           // Raise one flag.
    input  wire logic [4:0]  idx,            // Flag number, 0 to 24.
    output logic      [24:0] hwSet = 25'h0   // One-cycle set pulses.
);
    always @(posedge clock) begin
        hwSet <= fire ? (25'h1 << idx) : 25'h0;
    end
endmodule // irm_flag_src

// ### tb/irm_core_tb.sv
// Self-checking bench for irm_core with the flag source model beside it.
// Assumes a 200 MHz clock and registered answers one edge after a request.
`timescale 1ns/1ps
module irm_core_tb;
    logic        clock, rst_n, req, reqWrite, reqByte, reqFetch, reqTransfer, reqGpr, reqPaged;
    logic        bitOp, bitVal, push, pop, cpWrite, ctxSwitch, limitWrite, fire, gV, gE, gX;
    logic        rvalid, accessErr, extAccess, stackOvf, stackUnf, circular;
    logic [3:0]  gprIndex, bitPos;
    logic [23:0] reqAddr;
    logic [1:0]  pageSel;
    logic [9:0]  pagePtr;
    logic [15:0] reqWdata, cpWdata, lowLimitW, highLimitW, rdata, cpNow, cpSaved, gD;
    logic [15:0] spOut, stackLowReg, stackHighReg;
    logic [2:0]  stackSize;
    logic [4:0]  idx;
    logic [24:0] hwSet, swTarget, swValue, protFlags;
    int          error_cnt = 0, cmp_count = 0, i;
    irm_flag_src SRC (.clock, .fire, .idx, .hwSet);
    irm_core DUT (.clock, .rst_n, .req, .reqWrite, .reqByte, .reqFetch, .reqTransfer, .reqGpr,
        .gprIndex, .reqAddr, .pageSel, .pagePtr, .reqPaged, .reqWdata, .bitOp, .bitPos, .bitVal,
        .stackSize, .push, .pop, .cpWrite, .ctxSwitch, .cpWdata, .lowLimitW, .highLimitW,
        .limitWrite, .hwSet, .swTarget, .swValue, .rdata, .rvalid, .accessErr, .extAccess,
        .cpNow, .cpSaved, .spOut, .stackLowReg, .stackHighReg, .stackOvf, .stackUnf, .circular,
        .protFlags);
    always #2.5 clock = ~clock;
    // Answers are single-cycle pulses, so they are latched here for the tasks to inspect.
    always @(posedge clock) begin
        if (rvalid === 1'h1) gD <= rdata;
        if (rvalid === 1'h1) gV <= 1'h1;
        if (accessErr === 1'h1) gE <= 1'h1;
        if (extAccess === 1'h1) gX <= 1'h1;
    end
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input [24:0] got, input [24:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Mode m is {fetch, paged, transfer, bank, bit}; for bit accesses d[3:0] is the position.
    task automatic acc(input w, input [4:0] m, input [23:0] a, input [15:0] d);
        int n;
        @(posedge clock);
        {req, reqWrite, reqAddr, reqWdata, gprIndex} <= {1'h1, w, a, d, a[3:0]};
        {reqFetch, reqPaged, reqTransfer, reqGpr, bitOp} <= m;
        {bitPos, bitVal} <= {d[3:0], d[4]};
        {gV, gE, gX} = 3'h0;
        @(posedge clock);
        {req, reqFetch, reqPaged, reqTransfer, reqGpr, bitOp} <= 6'h0;
        #1;
        for (n = 0; n < 8 && !w && !(gV | gE | gX); n++) begin
            @(posedge clock);
            #1;
        end
        if (!w && !(gV | gE | gX)) begin
            error_cnt++;
            close_out();
        end
        if (w) repeat (2) @(posedge clock);
    endtask
    task automatic pls(input [4:0] k, input [15:0] v, input [24:0] t);
        @(posedge clock);
        {push, pop, cpWrite, ctxSwitch, limitWrite} <= k;
        {reqWdata, cpWdata, lowLimitW, swTarget} <= {v, v, v, t};
        @(posedge clock);
        {push, pop, cpWrite, ctxSwitch, limitWrite, swTarget} <= 30'h0;
        repeat (4) @(posedge clock);
        #1;
    endtask
    initial begin
        {clock, rst_n, req, reqWrite, reqByte, reqFetch, reqTransfer, reqGpr, reqPaged} = 9'h0;
        {bitOp, bitVal, push, pop, cpWrite, ctxSwitch, limitWrite, fire, gV, gE, gX} = 11'h0;
        {gprIndex, bitPos, reqAddr, pageSel, pagePtr, stackSize, idx} = 52'h0;
        {reqWdata, cpWdata, lowLimitW, swTarget, swValue} = 98'h0;
        highLimitW = 16'hFC00;
        repeat (20) @(posedge clock);
        chk(cpNow, 16'hFC00, "cp reset");
        chk(spOut, 16'hFC00, "sp reset");
        chk({stackLowReg, stackHighReg}, {16'hFA00, 16'hFC00}, "limits reset");
        chk(protFlags, 25'h0, "flags reset");
        rst_n <= 1'h1;
        acc(1'h1, 5'h00, 24'h00FD00, 16'hA55A);
        acc(1'h1, 5'h00, 24'h00FD02, 16'h1234);
        acc(1'h1, 5'h01, 24'h00FD00, 16'h000F);
        acc(1'h0, 5'h00, 24'h00FD00, 16'h0); chk(gD, 16'h255A, "bit 15 clear");
        acc(1'h0, 5'h00, 24'h00FD02, 16'h0); chk(gD, 16'h1234, "odd word");
        $display("test memory done");
        acc(1'h0, 5'h10, 24'h00FD01, 16'h0); chk(gE, 1'h1, "odd fetch");
        acc(1'h0, 5'h10, 24'h00FE00, 16'h0); chk(gE, 1'h1, "register fetch");
        acc(1'h0, 5'h01, 24'h00FA00, 16'h0); chk(gE, 1'h1, "bit outside");
        acc(1'h0, 5'h01, 24'h00F100, 16'h0); chk(gE, 1'h0, "bit extended area");
        acc(1'h0, 5'h01, 24'h00FF00, 16'h0); chk(gE, 1'h0, "bit register area");
        pagePtr <= 10'h2;
        acc(1'h0, 5'h08, 24'h003D00, 16'h0); chk(gX, 1'h1, "page two");
        pagePtr <= 10'h3;
        acc(1'h0, 5'h08, 24'h003D00, 16'h0); chk(gD, 16'h255A, "page three");
        pagePtr <= 10'h0;
        acc(1'h0, 5'h04, 24'h00FD02, 16'h0); chk(gD, 16'h1234, "transfer");
        acc(1'h0, 5'h00, 24'h010000, 16'h0); chk(gX, 1'h1, "segment one");
        acc(1'h0, 5'h00, 24'h00E000, 16'h0); chk(gX, 1'h1, "below area");
        reqByte <= 1'h1;
        acc(1'h1, 5'h00, 24'h00FE01, 16'h00AB);
        reqByte <= 1'h0;
        acc(1'h0, 5'h00, 24'h00FE00, 16'h0); chk(gD, 16'hAB00, "byte clears low");
        $display("test decode done");
        pls(5'h10, 16'h1111, 25'h0);
        pls(5'h10, 16'h2222, 25'h0); chk(spOut, 16'hFBFC, "two pushes");
        acc(1'h0, 5'h00, 24'h00FBFC, 16'h0); chk(gD, 16'h2222, "stack top");
        acc(1'h0, 5'h00, 24'h00FBFE, 16'h0); chk(gD, 16'h1111, "stack below");
        pls(5'h08, 16'h0, 25'h0); chk(spOut, 16'hFBFE, "pop");
        pls(5'h01, 16'hFB00, 25'h0); chk(stackLowReg, 16'hFB00, "low limit");
        for (i = 0; i < 5; i++) begin
            stackSize <= (i == 4) ? 3'h7 : i[2:0];
            repeat (4) @(posedge clock);
            #1;
            chk(circular, (i != 4), "circular");
        end
        $display("test stack done");
        pls(5'h04, 16'hFD40, 25'h0); chk(cpNow, 16'hFD40, "cp load");
        acc(1'h1, 5'h02, 24'h000001, 16'hBEEF);
        acc(1'h0, 5'h00, 24'h00FD42, 16'h0); chk(gD, 16'hBEEF, "bank word one");
        pls(5'h02, 16'hFD60, 25'h0); chk({cpNow, cpSaved}, {16'hFD60, 16'hFD40}, "switch");
        $display("test context done");
        for (i = 0; i < 25; i++) begin
            @(posedge clock);
            {fire, idx} <= {1'h1, i[4:0]};
            @(posedge clock);
            fire <= 1'h0;
            pls(5'h0, 16'h0, ~(25'h1 << i)); chk(protFlags[i], 1'h1, "flag kept");
            pls(5'h0, 16'h0, 25'h1 << i); chk(protFlags[i], 1'h0, "flag cleared");
        end
        $display("test protection done");
        close_out();
    end
endmodule // irm_core_tb
